// ### rtl/hwseq_pkg.sv
// Constants shared by the waveform sequencer slot logic and its tick divider.
// Assumes one 200 MHz core clock and a byte-wide register port.
`default_nettype none
package hwseq_pkg;
	// Register map
	localparam logic [7:0] GO_ADDR        = 8'h0c;
	localparam logic [7:0] SLOT_BASE_ADDR = 8'h0f;
	localparam logic [7:0] SLOT_TWO_ADDR  = 8'h10;
	localparam logic [7:0] SLOT_LAST_ADDR = 8'h16;
	localparam int         SLOT_COUNT     = 8;
	localparam logic [2:0] SLOT_LAST_IDX  = 3'h7;

	// Field positions
	localparam int GO_BIT       = 0;
	localparam int DELAY_SEL_BIT = 7;

	// Reset values
	localparam logic [7:0] SLOT_ONE_RST = 8'h01;
	localparam logic [7:0] SLOT_RST     = 8'h00;
	localparam logic       GO_RST       = 1'b0;

	// Timing: one unit of slot delay
	localparam int CLK_MHZ       = 200;
	localparam int WAIT_UNIT_MS  = 10;
	localparam int WAIT_UNIT_CYC = WAIT_UNIT_MS * CLK_MHZ * 1000;
	localparam int TICK_W        = 24;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_PLAY,
		ST_WAIT
	} hwseq_state_t;
endpackage
`default_nettype wire

// ### rtl/hwseq_tick.sv
// Delay-unit divider: one-cycle pulse every TICK_CYCLES clocks.
// Held at zero while clear is high, so the first pulse comes a full
// unit after clear drops.
`default_nettype none
module hwseq_tick #(
	parameter int TICK_CYCLES = hwseq_pkg::WAIT_UNIT_CYC
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// Control
	input  wire logic tickClear,
	output logic      tickPulse
);
	typedef struct packed {
		logic [hwseq_pkg::TICK_W-1:0] count;
		logic                         pulse;
	} hwseq_tick_t;

	localparam int TOP_INT = TICK_CYCLES - 1;
	localparam logic [hwseq_pkg::TICK_W-1:0] TOP =
		TOP_INT[hwseq_pkg::TICK_W-1:0];

	hwseq_tick_t tick_reg;
	hwseq_tick_t tick_next;

	always_comb begin
		tick_next = tick_reg;
		tick_next.pulse = 1'b0;
		if (tickClear) begin
			tick_next.count = '0;
		end else if (tick_reg.count == TOP) begin
			tick_next.count = '0;
			tick_next.pulse = 1'b1;
		end else begin
			tick_next.count = tick_reg.count + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tick_reg <= '0;
		end else begin
			tick_reg <= tick_next;
		end
	end

	assign tickPulse = tick_reg.pulse;
endmodule
`default_nettype wire

// ### rtl/hwseq_slots.sv
// Eight-slot waveform sequencer with its go trigger and slot registers.
// Assumes a waveform player that takes playReq/playId and answers playDone.
//
// Design decision made here: the plain strobed port.
`default_nettype none
module hwseq_slots #(
	parameter int WAIT_CYCLES = hwseq_pkg::WAIT_UNIT_CYC
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// Register port
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdData,
	// Triggers and status
	input  wire logic       extTrig,
	output logic            seqBusy,
	output logic            seqCancel,
	// Waveform player
	output logic            playReq,
	output logic      [6:0] playId,
	input  wire logic       playDone
);
	typedef struct packed {
		logic                        goBit;
		logic [7:0][7:0]             slots;
		hwseq_pkg::hwseq_state_t     state;
		logic [2:0]                  idx;
		logic [6:0]                  waitCnt;
		logic [7:0]                  rdData;
		logic                        playReq;
		logic [6:0]                  playId;
		logic                        cancel;
	} hwseq_regs_t;

	hwseq_regs_t seq_reg;
	hwseq_regs_t seq_next;

	logic       tickPulse;
	logic       tickClear;
	logic [7:0] slotOff;
	logic       slotHit;
	logic [7:0] curSlot;
	logic       seqDone;

	// Delay slots are timed from entry into the wait state
	assign tickClear = (seq_reg.state != hwseq_pkg::ST_WAIT);

	hwseq_tick #(
		.TICK_CYCLES(WAIT_CYCLES)
	) u_tick (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.tickClear(tickClear),
		.tickPulse(tickPulse)
	);

	assign slotOff = regAddr - hwseq_pkg::SLOT_BASE_ADDR;
	assign slotHit = (regAddr >= hwseq_pkg::SLOT_BASE_ADDR) &&
		(regAddr <= hwseq_pkg::SLOT_LAST_ADDR);
	assign curSlot = seq_reg.slots[seq_reg.idx];

	always_comb begin
		seq_next = seq_reg;
		seq_next.playReq = 1'b0;
		seq_next.cancel = 1'b0;
		seqDone = 1'b0;

		// Register writes; slots may be rewritten during playback and the
		// new value is used when that slot is reached
		if (regWrite && slotHit) begin
			seq_next.slots[slotOff[2:0]] = regWrData;
		end

		// Read data stands only in the cycle after the strobe
		seq_next.rdData = 8'h00;
		if (regRead) begin
			if (slotHit) begin
				seq_next.rdData = seq_reg.slots[slotOff[2:0]];
			end else if (regAddr == hwseq_pkg::GO_ADDR) begin
				seq_next.rdData = {7'h00, seq_reg.goBit};
			end
		end

		case (seq_reg.state)
			hwseq_pkg::ST_IDLE: begin
				if (seq_reg.goBit) begin
					seq_next.state = hwseq_pkg::ST_FETCH;
					seq_next.idx = 3'h0;
				end
			end
			hwseq_pkg::ST_FETCH: begin
				if (curSlot[hwseq_pkg::DELAY_SEL_BIT]) begin
					seq_next.state = hwseq_pkg::ST_WAIT;
					seq_next.waitCnt = curSlot[6:0];
				end else if (curSlot[6:0] == 7'h00) begin
					seqDone = 1'b1;
					seq_next.state = hwseq_pkg::ST_IDLE;
				end else begin
					seq_next.state = hwseq_pkg::ST_PLAY;
					seq_next.playReq = 1'b1;
					seq_next.playId = curSlot[6:0];
				end
			end
			hwseq_pkg::ST_PLAY: begin
				if (playDone) begin
					if (seq_reg.idx == hwseq_pkg::SLOT_LAST_IDX) begin
						seqDone = 1'b1;
						seq_next.state = hwseq_pkg::ST_IDLE;
					end else begin
						seq_next.idx = seq_reg.idx + 3'h1;
						seq_next.state = hwseq_pkg::ST_FETCH;
					end
				end
			end
			hwseq_pkg::ST_WAIT: begin
				if (seq_reg.waitCnt == 7'h00) begin
					if (seq_reg.idx == hwseq_pkg::SLOT_LAST_IDX) begin
						seqDone = 1'b1;
						seq_next.state = hwseq_pkg::ST_IDLE;
					end else begin
						seq_next.idx = seq_reg.idx + 3'h1;
						seq_next.state = hwseq_pkg::ST_FETCH;
					end
				end else if (tickPulse) begin
					seq_next.waitCnt = seq_reg.waitCnt - 7'h01;
				end
			end
			default: begin
				seq_next.state = hwseq_pkg::ST_IDLE;
			end
		endcase

		// Completion clears go, but a set in the same cycle wins
		if (seqDone) begin
			seq_next.goBit = 1'b0;
		end
		if (regWrite && regAddr == hwseq_pkg::GO_ADDR) begin
			seq_next.goBit = regWrData[hwseq_pkg::GO_BIT];
		end
		if (extTrig) begin
			seq_next.goBit = 1'b1;
		end

		// Software cleared go: drop everything now; a clear that lands on
		// the start cycle keeps the sequencer idle with no cancel pulse
		if (seq_next.state != hwseq_pkg::ST_IDLE && !seq_next.goBit) begin
			seq_next.state = hwseq_pkg::ST_IDLE;
			seq_next.playReq = 1'b0;
			seq_next.cancel = (seq_reg.state != hwseq_pkg::ST_IDLE);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			seq_reg <= '0;
			seq_reg.goBit <= hwseq_pkg::GO_RST;
			for (int i = 0; i < hwseq_pkg::SLOT_COUNT; i++) begin
				seq_reg.slots[i] <= hwseq_pkg::SLOT_RST;
			end
			seq_reg.slots[0] <= hwseq_pkg::SLOT_ONE_RST;
			seq_reg.state <= hwseq_pkg::ST_IDLE;
		end else begin
			seq_reg <= seq_next;
		end
	end

	assign regRdData = seq_reg.rdData;
	assign seqBusy = (seq_reg.state != hwseq_pkg::ST_IDLE);
	assign seqCancel = seq_reg.cancel;
	assign playReq = seq_reg.playReq;
	assign playId = seq_reg.playId;

	// Checks
	AST_DELAY_SELECT: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(seq_reg.state == hwseq_pkg::ST_FETCH && curSlot[7] && seq_next.goBit)
		|=> (seq_reg.state == hwseq_pkg::ST_WAIT && !playReq))
		else $error("delay slot did not enter wait");

	AST_ID_PLAY: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(seq_reg.state == hwseq_pkg::ST_FETCH && !curSlot[7] &&
		curSlot[6:0] != 7'h00 && seq_next.goBit)
		|=> (seq_reg.state == hwseq_pkg::ST_PLAY && playReq))
		else $error("id slot did not request playback");

	AST_WAIT_TICK: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(seq_reg.state == hwseq_pkg::ST_WAIT && tickPulse &&
		seq_reg.waitCnt != 7'h00 && seq_next.goBit)
		|=> (seq_reg.waitCnt == $past(seq_reg.waitCnt) - 7'h01))
		else $error("wait count did not step on tick");

	AST_WAIT_HOLD: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(seq_reg.state == hwseq_pkg::ST_WAIT && !tickPulse &&
		seq_reg.waitCnt != 7'h00 && seq_next.goBit)
		|=> (seq_reg.state == hwseq_pkg::ST_WAIT &&
		$stable(seq_reg.waitCnt) && $stable(seq_reg.idx)))
		else $error("wait slot moved without a tick");

	AST_WAIT_EXIT: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(seq_reg.state == hwseq_pkg::ST_WAIT && seq_reg.waitCnt == 7'h00 &&
		seq_reg.idx != hwseq_pkg::SLOT_LAST_IDX && seq_next.goBit)
		|=> (seq_reg.state == hwseq_pkg::ST_FETCH &&
		seq_reg.idx == $past(seq_reg.idx) + 3'h1))
		else $error("expired wait did not move to next slot");

	// Checked against the slot as it stood when fetched, since software
	// may rewrite it in the very cycle the request goes out
	AST_PLAY_ID: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		playReq |-> (playId == $past(curSlot[6:0]) &&
		seq_reg.state == hwseq_pkg::ST_PLAY))
		else $error("played id differs from slot");

	AST_START_FIRST: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(seq_reg.state == hwseq_pkg::ST_IDLE && seq_reg.goBit &&
		seq_next.goBit)
		|=> (seq_reg.idx == 3'h0 && seqBusy))
		else $error("sequence did not start at first slot");

	AST_GO_SET: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(regWrite && regAddr == hwseq_pkg::GO_ADDR &&
		regWrData[hwseq_pkg::GO_BIT])
		|=> seq_reg.goBit)
		else $error("go write did not set go");

	AST_ADVANCE: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(seq_reg.state == hwseq_pkg::ST_PLAY && playDone &&
		seq_reg.idx != 3'h7 && seq_next.goBit)
		|=> (seq_reg.state == hwseq_pkg::ST_FETCH &&
		seq_reg.idx == $past(seq_reg.idx) + 3'h1))
		else $error("sequencer did not advance");

	AST_PLAY_HOLD: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(seq_reg.state == hwseq_pkg::ST_PLAY && !playDone && seq_next.goBit)
		|=> (seq_reg.state == hwseq_pkg::ST_PLAY && $stable(seq_reg.idx) &&
		!playReq))
		else $error("play state left before waveform ended");

	AST_FETCH_ONE: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		seq_reg.state == hwseq_pkg::ST_FETCH
		|=> seq_reg.state != hwseq_pkg::ST_FETCH)
		else $error("slot fetch took more than one cycle");

	AST_ZERO_STOP: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(seq_reg.state == hwseq_pkg::ST_FETCH && curSlot == 8'h00 &&
		!extTrig && !regWrite)
		|=> (!seqBusy && !seq_reg.goBit && !playReq))
		else $error("zero id did not stop sequence");

	AST_LAST_STOP: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(seq_reg.state == hwseq_pkg::ST_PLAY && playDone &&
		seq_reg.idx == 3'h7 && !extTrig && !regWrite)
		|=> (!seqBusy && !seq_reg.goBit))
		else $error("sequence ran past eighth slot");

	AST_WAIT_LAST: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(seq_reg.state == hwseq_pkg::ST_WAIT && seq_reg.waitCnt == 7'h00 &&
		seq_reg.idx == hwseq_pkg::SLOT_LAST_IDX && !extTrig && !regWrite)
		|=> (!seqBusy && !seq_reg.goBit))
		else $error("sequence ran past a final delay slot");

	// A run that completes in the same cycle ends normally, not cancelled
	AST_CANCEL: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(seqBusy && !seqDone && regWrite && regAddr == hwseq_pkg::GO_ADDR &&
		!regWrData[0] && !extTrig)
		|=> (!seqBusy && seqCancel && !playReq))
		else $error("go clear did not cancel");

	AST_GO_HOLDS: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		seqBusy |-> seq_reg.goBit)
		else $error("go bit low while running");

	AST_IDLE_QUIET: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		!seqBusy |-> !playReq)
		else $error("play request while idle");

	AST_EXT_TRIG: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(extTrig && !seqBusy && !seq_reg.goBit)
		|=> (seq_reg.goBit ##1 (seqBusy || !seq_reg.goBit)))
		else $error("external trigger did not start");

	AST_TRIG_SETS: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		extTrig |=> seq_reg.goBit)
		else $error("external trigger did not set go");

	AST_SLOT_STORE: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(regWrite && slotHit)
		|=> (seq_reg.slots[$past(slotOff[2:0])] == $past(regWrData)))
		else $error("slot write not stored");

	AST_RD_QUIET: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		!$past(regRead) |-> (regRdData == 8'h00))
		else $error("read data outside its cycle");
endmodule
`default_nettype wire

// ### sim/hwseq_slots_tb.sv
// Self-checking bench for the eight-slot waveform sequencer.
// Drives the register port, triggers and player handshake itself.
`default_nettype none
`define CHK(g, e) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("wrong value at %0t: got %h exp %h", $time, g, e); \
	end \
end
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	// Short delay unit keeps wait slots to a few dozen cycles
	localparam int W = 8;
	logic       core_clk;
	logic       sys_rst;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic       regWrite;
	logic       regRead;
	logic [7:0] regRdData;
	logic       extTrig;
	logic       seqBusy;
	logic       seqCancel;
	logic       playReq;
	logic [6:0] playId;
	logic       playDone;
	integer     seed = 32'h550bdda2;
	int         miscompares = 0;
	int         check_count = 0;
	int         reqs = 0;
	int         k;
	int         n;
	logic [7:0] ids [8];

	hwseq_slots #(.WAIT_CYCLES(W)) i_hwseq_slots (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.regAddr  (regAddr),
		.regWrData(regWrData),
		.regWrite (regWrite),
		.regRead  (regRead),
		.regRdData(regRdData),
		.extTrig  (extTrig),
		.seqBusy  (seqBusy),
		.seqCancel(seqCancel),
		.playReq  (playReq),
		.playId   (playId),
		.playDone (playDone)
	);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (playReq === 1'b1) reqs++;
	end

	task automatic test_done;
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask

	// Read data only stands in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1;
		`CHK(regRdData, e)
	endtask

	function automatic logic [7:0] rnd_id();
		logic [6:0] v;
		v = 7'($random(seed));
		if (v == 7'h00) v = 7'h7f;
		return {1'b0, v};
	endfunction

	task automatic load;
		for (int i = 0; i < 8; i++)
			wr(hwseq_pkg::SLOT_BASE_ADDR + 8'(i), ids[i]);
	endtask

	// Returns the cycles waited, so delay slots can be timed
	task automatic wait_req(input logic [7:0] id, output int c);
		c = 0;
		do begin
			@(posedge core_clk);
			#1;
			c++;
		end while (playReq !== 1'b1 && c < 1000);
		`CHK(playReq, 1'b1)
		`CHK(playId, id[6:0])
	endtask

	task automatic done_pulse;
		@(posedge core_clk);
		playDone <= 1'b1;
		@(posedge core_clk);
		playDone <= 1'b0;
	endtask

	// Sequence must have ended, go cleared, and no stray request
	task automatic end_chk;
		n = reqs;
		repeat (4) @(posedge core_clk);
		#1;
		`CHK(seqBusy, 1'b0)
		`CHK(reqs, n)
		rd(hwseq_pkg::GO_ADDR, 8'h00);
	endtask

	initial begin
		repeat (5000) @(posedge core_clk);
		miscompares++;
		test_done;
	end

	initial begin
		sys_rst = 1'b1;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		extTrig = 1'b0;
		playDone = 1'b0;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(hwseq_pkg::SLOT_BASE_ADDR, 8'h01);
		for (int i = 1; i < 8; i++)
			rd(hwseq_pkg::SLOT_BASE_ADDR + 8'(i), 8'h00);
		rd(hwseq_pkg::GO_ADDR, 8'h00);
		rd(8'h20, 8'h00);
		for (int i = 0; i < 8; i++) ids[i] = 8'($random(seed));
		load;
		for (int i = 0; i < 8; i++)
			rd(hwseq_pkg::SLOT_BASE_ADDR + 8'(i), ids[i]);
		// All eight slots play, then the run stops by itself
		for (int i = 0; i < 8; i++) ids[i] = rnd_id();
		load;
		wr(hwseq_pkg::GO_ADDR, 8'h01);
		for (int i = 0; i < 8; i++) begin
			wait_req(ids[i], k);
			if (i == 0) rd(hwseq_pkg::GO_ADDR, 8'h01);
			done_pulse;
		end
		end_chk;
		// Delays of two units and of zero, then a zero terminator
		ids[1] = 8'h82;
		ids[3] = 8'h80;
		ids[5] = 8'h00;
		load;
		wr(hwseq_pkg::GO_ADDR, 8'h01);
		wait_req(ids[0], k);
		done_pulse;
		wait_req(ids[2], k);
		`CHK(k >= 2 * W && k <= 2 * W + 8, 1'b1)
		done_pulse;
		wait_req(ids[4], k);
		done_pulse;
		end_chk;
		// Software clears go mid-play; upper go bits are not stored
		wr(hwseq_pkg::GO_ADDR, 8'hff);
		wait_req(ids[0], k);
		rd(hwseq_pkg::GO_ADDR, 8'h01);
		wr(hwseq_pkg::GO_ADDR, 8'h00);
		#1;
		`CHK(seqBusy, 1'b0)
		`CHK(seqCancel, 1'b1)
		end_chk;
		// External trigger starts a one-slot run, slot two now holding a zero terminator
		wr(hwseq_pkg::SLOT_TWO_ADDR, 8'h00);
		@(posedge core_clk);
		extTrig <= 1'b1;
		@(posedge core_clk);
		extTrig <= 1'b0;
		wait_req(ids[0], k);
		rd(hwseq_pkg::GO_ADDR, 8'h01);
		done_pulse;
		end_chk;
		// Eighth slot is a delay: the run ends when it expires
		for (int i = 0; i < 7; i++) ids[i] = rnd_id();
		ids[7] = 8'h81;
		load;
		wr(hwseq_pkg::GO_ADDR, 8'h01);
		for (int i = 0; i < 7; i++) begin
			wait_req(ids[i], k);
			done_pulse;
		end
		repeat (W) @(posedge core_clk);
		end_chk;
		test_done;
	end
endmodule
`default_nettype wire
